// File: drap_flash_model.sv
// Behavioural flash data array on the far side of the access port
`default_nettype none
module drap_flash_model #(
	parameter int LAT = 4
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [18:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic prog_i,
	input wire logic erase_i,
	output logic [7:0] rdata_o,
	output logic done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [int];
	int cnt = 0;
	int ver = 0;
	// Unwritten bytes show an address pattern; erase returns to it to keep expectations cheap
	always @(addr_i or ver) begin
		rdata_o = mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : (addr_i[7:0] ^ 8'h5a);
	end
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt = 0;
			done_o <= 1'b0;
		end else begin
			done_o <= (cnt == 1);
			if (cnt != 0) cnt--;
			if (prog_i) begin
				mem[int'(addr_i)] = wdata_i;
				cnt = LAT;
				// Read byte moves after the edge, so the port never races the update
				ver <= ver + 1;
			end
			if (erase_i) begin
				mem.delete();
				cnt = LAT;
				ver <= ver + 1;
			end
		end
	end
endmodule
`default_nettype wire

// File: drap_pkg.sv
// Constants, types and register map for the data ROM access port
`default_nettype none
package drap_pkg;
	localparam int ADDR_W = 19;
	localparam logic [4:0] OFS_ADDR0 = 5'h18;
	localparam logic [4:0] OFS_ADDR1 = 5'h19;
	localparam logic [4:0] OFS_ADDR2 = 5'h1a;
	localparam logic [4:0] OFS_ADDR3 = 5'h1b;
	localparam logic [4:0] OFS_DATA_LO = 5'h1c;
	localparam logic [4:0] OFS_DATA_HI = 5'h1d;
	localparam logic [4:0] OFS_ADDR_TOP = 5'h1e;
	localparam logic [4:0] OFS_NVM_START = 5'h0b;
	localparam logic [4:0] OFS_NVM_STATUS = 5'h0c;
	localparam int BIT_PROG_START = 3;
	localparam int BIT_ERASE_START = 2;
	localparam int BIT_IRQ_EN = 1;
	localparam int BIT_DONE = 0;
	localparam logic [3:0] RST_NIBBLE = 4'h0;
	localparam logic [1:0] RST_TOP = 2'h0;

	typedef enum logic [2:0] {
		OP_IDLE = 3'b001,
		OP_PROG = 3'b010,
		OP_ERASE = 3'b100
	} drap_op_e;

	// One register access from the core: common space or extended space
	typedef struct packed {
		logic wr;
		logic exio;
		logic [4:0] addr;
		logic [3:0] wdata;
	} drap_req_s;

	typedef struct packed {
		logic [3:0] a0;
		logic [3:0] a1;
		logic [3:0] a2;
		logic [3:0] a3;
		logic [1:0] a4;
		logic [3:0] dl;
		logic [3:0] dh;
		logic prog;
		logic erase;
		logic irq_en;
		logic done;
		logic refresh;
		drap_op_e op;
		logic strobe_p;
		logic strobe_e;
		logic [3:0] rdata;
		logic irq;
	} drap_state_s;
endpackage
`default_nettype wire

// File: drap_port.sv
// Register access port from the 4-bit core to the flash data array
`default_nettype none
// What this block does
// - The byte address is the five address nibbles joined, nibble 0 lowest, 19 bits wide.
// - Only the low two bits of the top address nibble exist; the rest read zero and it resets to zero.
// - Each address register write, and reset, reloads one 8-bit byte from the array at the assembled address.
// - The low data register shows the low nibble read and holds the low nibble to program.
// - The high data register shows the high nibble read and holds the high nibble to program.
// - Setting the program start bit programs the held byte at the address, then the bit clears itself.
// - Setting the erase start bit runs an erase, then the bit clears itself.
// - A completion flag goes high when a program or erase finishes and is zero until then.
// - With the completion interrupt enable set, completion raises an interrupt; cleared, it does not.
module drap_port (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire drap_pkg::drap_req_s req_i,
	output logic [3:0] sfr_rdata_o,
	output logic [drap_pkg::ADDR_W-1:0] flash_addr_o,
	input wire logic [7:0] flash_rdata_i,
	output logic [7:0] flash_wdata_o,
	output logic flash_prog_o,
	output logic flash_erase_o,
	input wire logic flash_done_i,
	output logic irq_o
);
	import drap_pkg::*;

	drap_state_s s;
	drap_state_s next_s;
	logic wr_c;
	logic wr_x;

	assign wr_c = req_i.wr && !req_i.exio;
	assign wr_x = req_i.wr && req_i.exio;

	always_comb begin
		next_s = s;
		next_s.refresh = 1'b0;
		next_s.strobe_p = 1'b0;
		next_s.strobe_e = 1'b0;
		// Reload runs the cycle after the address settles, since the array read is combinational
		if (s.refresh) begin
			next_s.dl = flash_rdata_i[3:0];
			next_s.dh = flash_rdata_i[7:4];
		end
		if (wr_c) begin
			case (req_i.addr)
				OFS_ADDR0: begin
					next_s.a0 = req_i.wdata;
					next_s.refresh = 1'b1;
				end
				OFS_ADDR1: begin
					next_s.a1 = req_i.wdata;
					next_s.refresh = 1'b1;
				end
				OFS_ADDR2: begin
					next_s.a2 = req_i.wdata;
					next_s.refresh = 1'b1;
				end
				OFS_ADDR3: begin
					next_s.a3 = req_i.wdata;
					next_s.refresh = 1'b1;
				end
				OFS_ADDR_TOP: begin
					next_s.a4 = req_i.wdata[1:0];
					next_s.refresh = 1'b1;
				end
				OFS_DATA_LO: next_s.dl = req_i.wdata;
				OFS_DATA_HI: next_s.dh = req_i.wdata;
				default: ;
			endcase
		end
		if (wr_x && req_i.addr == OFS_NVM_START) begin
			// Writing zero is ignored: only hardware clears a start bit
			// A start bit set again while its own operation runs merges into it and is not queued
			next_s.prog = s.prog | req_i.wdata[BIT_PROG_START];
			next_s.erase = s.erase | req_i.wdata[BIT_ERASE_START];
		end
		if (wr_x && req_i.addr == OFS_NVM_STATUS) begin
			next_s.irq_en = req_i.wdata[BIT_IRQ_EN];
			next_s.done = s.done & req_i.wdata[BIT_DONE];
		end
		case (s.op)
			OP_IDLE: begin
				// Program wins when both start bits are set together
				if (s.prog) begin
					next_s.op = OP_PROG;
					next_s.strobe_p = 1'b1;
				end else if (s.erase) begin
					next_s.op = OP_ERASE;
					next_s.strobe_e = 1'b1;
				end
			end
			OP_PROG: begin
				if (flash_done_i) begin
					next_s.op = OP_IDLE;
					next_s.prog = 1'b0;
					next_s.done = 1'b1;
				end
			end
			OP_ERASE: begin
				if (flash_done_i) begin
					next_s.op = OP_IDLE;
					next_s.erase = 1'b0;
					next_s.done = 1'b1;
				end
			end
			default: next_s.op = OP_IDLE;
		endcase
		next_s.irq = next_s.done & next_s.irq_en;
		if (req_i.exio) begin
			case (req_i.addr)
				OFS_NVM_START: next_s.rdata = {s.prog, s.erase, 2'b00};
				OFS_NVM_STATUS: next_s.rdata = {2'b00, s.irq_en, s.done};
				default: next_s.rdata = 4'h0;
			endcase
		end else begin
			case (req_i.addr)
				OFS_ADDR0: next_s.rdata = s.a0;
				OFS_ADDR1: next_s.rdata = s.a1;
				OFS_ADDR2: next_s.rdata = s.a2;
				OFS_ADDR3: next_s.rdata = s.a3;
				OFS_ADDR_TOP: next_s.rdata = {2'b00, s.a4};
				OFS_DATA_LO: next_s.rdata = s.dl;
				OFS_DATA_HI: next_s.rdata = s.dh;
				default: next_s.rdata = 4'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s.a0 <= RST_NIBBLE;
			s.a1 <= RST_NIBBLE;
			s.a2 <= RST_NIBBLE;
			s.a3 <= RST_NIBBLE;
			s.a4 <= RST_TOP;
			s.dl <= RST_NIBBLE;
			s.dh <= RST_NIBBLE;
			s.prog <= 1'b0;
			s.erase <= 1'b0;
			s.irq_en <= 1'b0;
			s.done <= 1'b0;
			s.refresh <= 1'b1;
			s.op <= OP_IDLE;
			s.strobe_p <= 1'b0;
			s.strobe_e <= 1'b0;
			s.rdata <= 4'h0;
			s.irq <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// Bit 18 has no backing register since the top nibble keeps only two bits
	assign flash_addr_o = {1'b0, s.a4, s.a3, s.a2, s.a1, s.a0};
	assign flash_wdata_o = {s.dh, s.dl};
	assign flash_prog_o = s.strobe_p;
	assign flash_erase_o = s.strobe_e;
	assign sfr_rdata_o = s.rdata;
	assign irq_o = s.irq;

	AST_ADDR_LOW: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_c && req_i.addr == OFS_ADDR0 |=> flash_addr_o[3:0] == $past(req_i.wdata))
		else $error("Low address nibble not taken");
	AST_ADDR_TOP: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!req_i.exio && req_i.addr == OFS_ADDR_TOP |=> sfr_rdata_o[3:2] == 2'b00)
		else $error("Unimplemented top address bits read nonzero");
	AST_READ_BYTE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s.refresh && !(wr_c && (req_i.addr == OFS_DATA_LO || req_i.addr == OFS_DATA_HI))
		|=> flash_wdata_o == $past(flash_rdata_i))
		else $error("Data registers not loaded from array");
	AST_DATA_LO: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_c && req_i.addr == OFS_DATA_LO |=> flash_wdata_o[3:0] == $past(req_i.wdata))
		else $error("Low data nibble not held");
	AST_DATA_HI: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!req_i.exio && req_i.addr == OFS_DATA_HI |=> sfr_rdata_o == $past(s.dh))
		else $error("High data nibble not presented");
	AST_RELOAD: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_c && req_i.addr == OFS_ADDR2 |=> s.refresh)
		else $error("Address change did not start a reload");
	AST_PROG: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s.op == OP_IDLE && s.prog |=> flash_prog_o ##1 !flash_prog_o)
		else $error("Program strobe not one cycle");
	AST_ERASE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s.op == OP_ERASE && flash_done_i && !wr_x |=> !s.erase && s.op == OP_IDLE)
		else $error("Erase start bit not cleared at completion");
	AST_DONE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s.op != OP_IDLE && flash_done_i |=> s.done && irq_o == s.irq_en)
		else $error("Completion flag not set");
	AST_IRQ_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!s.irq_en || !s.done |-> !irq_o)
		else $error("Interrupt raised while disabled");

	// Further checks on address assembly, reload, data reads, start bits, the completion flag and the interrupt
	AST_ADDR_HIGH: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_c && req_i.addr == OFS_ADDR3 |=> flash_addr_o[15:12] == $past(req_i.wdata))
		else $error("High address nibble not taken");
	AST_ADDR_TOP_WR: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_c && req_i.addr == OFS_ADDR_TOP |=> flash_addr_o[18:16] == {1'b0, $past(req_i.wdata[1:0])})
		else $error("Top address bits not taken as two bits");
	AST_RELOAD_TOP: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_c && req_i.addr == OFS_ADDR_TOP |=> s.refresh)
		else $error("Top address change did not start a reload");
	AST_DATA_LO_READ: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!req_i.exio && req_i.addr == OFS_DATA_LO |=> sfr_rdata_o == $past(s.dl))
		else $error("Low data nibble not presented");
	AST_PROG_CLEAR: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s.op == OP_PROG && flash_done_i |=> !s.prog && s.op == OP_IDLE)
		else $error("Program start bit not cleared at completion");
	AST_ERASE_PULSE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s.op == OP_IDLE && !s.prog && s.erase |=> flash_erase_o ##1 !flash_erase_o)
		else $error("Erase strobe not one cycle");
	AST_DONE_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s.done && !(wr_x && req_i.addr == OFS_NVM_STATUS && !req_i.wdata[BIT_DONE]) |=> s.done)
		else $error("Completion flag dropped without a clear");
	AST_DONE_QUIET: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!s.done && !(s.op != OP_IDLE && flash_done_i) |=> !s.done)
		else $error("Completion flag rose without a completion");
	AST_IRQ_ON: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s.irq_en && s.done |-> irq_o)
		else $error("Interrupt missing while enabled and done");
endmodule
`default_nettype wire

// File: drap_port_tb.sv
// Self-checking testbench for the data ROM access port
`default_nettype none
module drap_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import drap_pkg::*;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	drap_req_s req_i = '0;
	logic [3:0] sfr_rdata_o;
	logic [18:0] flash_addr_o;
	logic [7:0] flash_rdata_i, flash_wdata_o;
	logic flash_prog_o, flash_erase_o, flash_done_i, irq_o;
	int error_cnt = 0;
	int checked = 0;
	drap_port u_drap_port (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .sfr_rdata_o(sfr_rdata_o),
		.flash_addr_o(flash_addr_o), .flash_rdata_i(flash_rdata_i), .flash_wdata_o(flash_wdata_o),
		.flash_prog_o(flash_prog_o), .flash_erase_o(flash_erase_o), .flash_done_i(flash_done_i), .irq_o(irq_o));
	drap_flash_model u_drap_flash_model (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(flash_addr_o),
		.wdata_i(flash_wdata_o), .prog_i(flash_prog_o), .erase_i(flash_erase_o), .rdata_o(flash_rdata_i),
		.done_o(flash_done_i));
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [18:0] g, input logic [18:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic x, input logic [4:0] a, input logic [3:0] d);
		@(posedge clk_i) req_i <= '{1'b1, x, a, d};
		@(posedge clk_i) req_i.wr <= 1'b0;
	endtask
	// Reads need no strobe; the two extra edges let a pending reload land first
	task automatic rd(input logic x, input logic [4:0] a, input logic [3:0] e);
		@(posedge clk_i) req_i <= '{1'b0, x, a, 4'h0};
		repeat (3) @(posedge clk_i);
		#1 chk({15'h0, sfr_rdata_o}, {15'h0, e});
	endtask
	task automatic op(input logic p);
		wr(1'b1, OFS_NVM_START, p ? 4'h8 : 4'h4);
		for (int i = 0; i < 9 && !(flash_prog_o | flash_erase_o); i++) begin
			@(posedge clk_i);
			#1;
		end
		chk({18'h0, flash_prog_o}, {18'h0, p});
		chk({18'h0, flash_erase_o}, {18'h0, !p});
		for (int i = 0; i < 20 && !flash_done_i; i++) begin
			@(posedge clk_i);
			#1;
		end
		chk({18'h0, flash_done_i}, 19'h1);
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	initial begin
		#(100 * 5000);
		error_cnt++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd(1'b0, OFS_DATA_LO, 4'ha);
		rd(1'b0, OFS_DATA_HI, 4'h5);
		rd(1'b0, OFS_ADDR_TOP, 4'h0);
		$display("test reset done");
		wr(1'b0, OFS_ADDR0, 4'h5);
		wr(1'b0, OFS_ADDR1, 4'h3);
		wr(1'b0, OFS_ADDR2, 4'ha);
		wr(1'b0, OFS_ADDR3, 4'hc);
		wr(1'b0, OFS_ADDR_TOP, 4'hf);
		rd(1'b0, OFS_ADDR_TOP, 4'h3);
		rd(1'b0, OFS_ADDR2, 4'ha);
		chk(flash_addr_o, 19'h3ca35);
		rd(1'b0, OFS_DATA_LO, 4'hf);
		rd(1'b0, OFS_DATA_HI, 4'h6);
		rd(1'b0, 5'h05, 4'h0);
		rd(1'b1, 5'h0d, 4'h0);
		$display("test address done");
		wr(1'b0, OFS_DATA_LO, 4'h7);
		wr(1'b0, OFS_DATA_HI, 4'h9);
		#1 chk({11'h0, flash_wdata_o}, 19'h97);
		wr(1'b1, OFS_NVM_STATUS, 4'h2);
		op(1'b1);
		chk({18'h0, irq_o}, 19'h1);
		rd(1'b1, OFS_NVM_START, 4'h0);
		rd(1'b1, OFS_NVM_STATUS, 4'h3);
		wr(1'b0, OFS_ADDR0, 4'h5);
		rd(1'b0, OFS_DATA_LO, 4'h7);
		rd(1'b0, OFS_DATA_HI, 4'h9);
		$display("test program done");
		wr(1'b1, OFS_NVM_STATUS, 4'h0);
		rd(1'b1, OFS_NVM_STATUS, 4'h0);
		op(1'b0);
		chk({18'h0, irq_o}, 19'h0);
		rd(1'b1, OFS_NVM_STATUS, 4'h1);
		rd(1'b1, OFS_NVM_START, 4'h0);
		wr(1'b0, OFS_ADDR0, 4'h5);
		rd(1'b0, OFS_DATA_LO, 4'hf);
		$display("test erase done");
		@(posedge clk_i) rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd(1'b0, OFS_ADDR_TOP, 4'h0);
		rd(1'b0, OFS_DATA_LO, 4'ha);
		rd(1'b1, OFS_NVM_STATUS, 4'h0);
		$display("test second reset done");
		conclude();
	end
endmodule
`default_nettype wire
